// [design/acwd_decoder.sv]
// apb-reachable decoder of the actuator motion control word
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module acwd_decoder (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  input  wire logic                  move_done,
  input  wire logic                  origin_done,
  output acwd_pkg::acwd_drive_t      drive,
  output acwd_pkg::acwd_move_t       move,
  output logic                       move_start,
  output logic                       origin_start,
  output logic                       move_busy,
  output logic                       origin_busy
);
  import acwd_pkg::*;

  logic [15:0]  ctrl_ff;
  logic [15:0]  nxt_ctrl;
  logic         cfg_heading_method_ff;
  logic [31:0]  width_ff;
  logic         fclr_prev_ff;
  logic         launch_prev_ff;
  logic         origin_prev_ff;
  acwd_motion_t state_ff;
  acwd_motion_t nxt_state;
  acwd_drive_t  drive_ff;
  acwd_move_t   move_ff;
  logic         move_start_ff;
  logic         origin_start_ff;
  logic [31:0]  prdata_ff;
  logic         pready_ff;
  logic         pslverr_ff;
  logic         move_busy_ff;
  logic         origin_busy_ff;

  // one wait state: answer registered in the access phase
  wire access    = psel && penable && !pready_ff;
  wire hit_ctrl  = paddr == ADDR_CTRL;
  wire hit_stat  = paddr == ADDR_STATUS;
  wire hit_cfg   = paddr == ADDR_CFG;
  wire hit_width = paddr == ADDR_WIDTH;
  wire mapped    = hit_ctrl || hit_stat || hit_cfg || hit_width;
  wire wr_ctrl   = access && pwrite && hit_ctrl;

  // reserved bits never stored, so they read back as zero
  assign nxt_ctrl = wr_ctrl ? (pwdata[15:0] & CTRL_WMASK) : ctrl_ff;

  wire launch_rise = ctrl_ff[BIT_LAUNCH] && !launch_prev_ff;
  wire origin_rise = ctrl_ff[BIT_ORIGIN] && !origin_prev_ff;
  wire fclr_rise   = ctrl_ff[BIT_FCLR] && !fclr_prev_ff;
  wire idle        = state_ff == ACWD_M_IDLE;

  // started commands latch and ignore the bit until the done input
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ACWD_M_IDLE: begin
        if (origin_rise)
          nxt_state = ACWD_M_ORIGIN;
        else if (launch_rise)
          nxt_state = ACWD_M_MOVE;
      end
      ACWD_M_MOVE: begin
        if (move_done)
          nxt_state = ACWD_M_IDLE;
      end
      ACWD_M_ORIGIN: begin
        if (origin_done)
          nxt_state = ACWD_M_IDLE;
      end
      default: nxt_state = ACWD_M_IDLE;
    endcase
  end

  wire take_move = idle && !origin_rise && launch_rise;

  // mode fields frozen at launch so later writes cannot disturb the move
  acwd_move_t nxt_move;
  always_comb begin
    nxt_move = move_ff;
    if (take_move) begin
      nxt_move.relative      = ctrl_ff[BIT_REL];
      nxt_move.press         = ctrl_ff[BIT_PRESS];
      nxt_move.heading_valid = ctrl_ff[BIT_PRESS] && cfg_heading_method_ff;
      nxt_move.heading_away  = ctrl_ff[BIT_PRESS] && cfg_heading_method_ff
                               && ctrl_ff[BIT_HEADING];
      nxt_move.press_travel  = ctrl_ff[BIT_PRESS] ? width_ff : 32'h0000_0000;
      nxt_move.tolerance     = ctrl_ff[BIT_PRESS] ? 32'h0000_0000 : width_ff;
    end
  end

  acwd_drive_t nxt_drive;
  always_comb begin
    nxt_drive.brake_free        = ctrl_ff[BIT_BRAKE];
    nxt_drive.servo_power       = ctrl_ff[BIT_SERVO];
    nxt_drive.pause_hold        = ctrl_ff[BIT_PAUSE];
    nxt_drive.fault_clear_pulse = fclr_rise;
    nxt_drive.manual_fwd        = ctrl_ff[BIT_FWD];
    nxt_drive.manual_rev        = ctrl_ff[BIT_REV];
    nxt_drive.manual_alt_set    = ctrl_ff[BIT_RATE];
    nxt_drive.manual_inch       = ctrl_ff[BIT_STEP];
  end

  wire [31:0] status_word = {28'h0000000, state_ff == ACWD_M_ORIGIN,
                             state_ff == ACWD_M_MOVE, move_ff.press, move_ff.relative};
  wire [31:0] rd_mux = hit_ctrl  ? {16'h0000, ctrl_ff} :
                       hit_stat  ? status_word :
                       hit_cfg   ? {31'h00000000, cfg_heading_method_ff} :
                       hit_width ? width_ff : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff               <= CTRL_RESET;
      cfg_heading_method_ff <= 1'b0;
      width_ff              <= WIDTH_RESET;
      pready_ff             <= 1'b0;
      pslverr_ff            <= 1'b0;
      prdata_ff             <= 32'h0000_0000;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      pready_ff  <= access;
      pslverr_ff <= access && !mapped;
      if (access && !pwrite)
        prdata_ff <= rd_mux;
      if (access && pwrite && hit_cfg)
        cfg_heading_method_ff <= pwdata[0];
      if (access && pwrite && hit_width)
        width_ff <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff        <= ACWD_M_IDLE;
      launch_prev_ff  <= 1'b0;
      origin_prev_ff  <= 1'b0;
      fclr_prev_ff    <= 1'b0;
      move_ff         <= '0;
      drive_ff        <= '0;
      move_start_ff   <= 1'b0;
      origin_start_ff <= 1'b0;
      move_busy_ff    <= 1'b0;
      origin_busy_ff  <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      launch_prev_ff  <= ctrl_ff[BIT_LAUNCH];
      origin_prev_ff  <= ctrl_ff[BIT_ORIGIN];
      fclr_prev_ff    <= ctrl_ff[BIT_FCLR];
      move_ff         <= nxt_move;
      drive_ff        <= nxt_drive;
      move_start_ff   <= take_move;
      origin_start_ff <= idle && origin_rise;
      // registered copies of the state decode keep the busy pins glitch free
      move_busy_ff    <= nxt_state == ACWD_M_MOVE;
      origin_busy_ff  <= nxt_state == ACWD_M_ORIGIN;
    end
  end

  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign prdata       = prdata_ff;
  assign drive        = drive_ff;
  assign move         = move_ff;
  assign move_start   = move_start_ff;
  assign origin_start = origin_start_ff;
  assign move_busy    = move_busy_ff;
  assign origin_busy  = origin_busy_ff;
endmodule

// [design/acwd_pkg.sv]
// constants, types and rule summary for the actuator control word decoder
// What this block does
// - bit 15 set releases the holding brake; clear keeps it engaged
// - bit 14 clear means absolute target; set means relative offset
// - press direction honoured only under the press method that uses it
// - bit 12 set requests pressing; clear requests ordinary positioning
// - bit 8 held moves away from origin; clearing it stops
// - bit 7 held moves toward origin; clearing it stops
// - bit 6 clear uses first manual parameter set; set uses alternate
// - bit 5 set gives inching steps; clear gives continuous jogging
// - bit 4 enables servo while set, disables while clear
// - rising edge of bit 3 performs one fault-clear reset
// - bit 2 held suspends motion; clearing it resumes
// - setting bit 1 while idle starts origin return, which runs to completion
// - setting bit 0 while idle starts the move unless bit 1 rises in the same write; the move runs to completion
// - in press mode the width field is press travel, not tolerance
package acwd_pkg;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_CFG       = 8'h08;
  localparam logic [7:0]  ADDR_WIDTH     = 8'h0C;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_WMASK     = 16'hF1FF;
  localparam int          BIT_BRAKE      = 15;
  localparam int          BIT_REL        = 14;
  localparam int          BIT_HEADING    = 13;
  localparam int          BIT_PRESS      = 12;
  localparam int          BIT_FWD        = 8;
  localparam int          BIT_REV        = 7;
  localparam int          BIT_RATE       = 6;
  localparam int          BIT_STEP       = 5;
  localparam int          BIT_SERVO      = 4;
  localparam int          BIT_FCLR       = 3;
  localparam int          BIT_PAUSE      = 2;
  localparam int          BIT_ORIGIN     = 1;
  localparam int          BIT_LAUNCH     = 0;
  localparam logic [31:0] WIDTH_RESET    = 32'h0000_0000;

  typedef enum logic [1:0] {ACWD_M_IDLE, ACWD_M_MOVE, ACWD_M_ORIGIN} acwd_motion_t;

  typedef struct packed {
    logic        relative;
    logic        press;
    logic        heading_valid;
    logic        heading_away;
    logic [31:0] press_travel;
    logic [31:0] tolerance;
  } acwd_move_t;

  typedef struct packed {
    logic brake_free;
    logic servo_power;
    logic pause_hold;
    logic fault_clear_pulse;
    logic manual_fwd;
    logic manual_rev;
    logic manual_alt_set;
    logic manual_inch;
  } acwd_drive_t;
endpackage

// [tb/acwd_monitor.sv]
// concurrent checks on the control word decoder ports
`timescale 1ns/1ps
module acwd_monitor (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic                  pready,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire acwd_pkg::acwd_drive_t drive,
  input wire acwd_pkg::acwd_move_t  move,
  input wire logic                  move_start,
  input wire logic                  origin_start,
  input wire logic                  move_busy,
  input wire logic                  origin_busy,
  input wire logic                  move_done,
  input wire logic                  origin_done
);
  import acwd_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ctrl_wr;
    psel && penable && !pready && pwrite && paddr == ADDR_CTRL;
  endsequence
  // drive levels land two edges after the taken write
  a_brake_servo: assert property (s_ctrl_wr |-> ##2
    drive.brake_free == $past(pwdata[15], 2) && drive.servo_power == $past(pwdata[4], 2)
    && drive.pause_hold == $past(pwdata[2], 2)) else $error("brake servo pause mismatch");
  a_manual_bits: assert property (s_ctrl_wr |-> ##2
    {drive.manual_fwd, drive.manual_rev, drive.manual_alt_set, drive.manual_inch}
    == $past(pwdata[8:5], 2)) else $error("manual bits mismatch");
  a_fclr_once: assert property (drive.fault_clear_pulse |=> !drive.fault_clear_pulse)
    else $error("fault clear pulse too long");
  a_origin_first: assert property (origin_start |-> origin_busy && !move_start)
    else $error("origin start not exclusive");
  a_origin_runs: assert property (origin_busy && !origin_done |=> origin_busy)
    else $error("origin return dropped");
  a_move_runs: assert property (move_busy && !move_done |=> move_busy)
    else $error("move dropped early");
  a_heading_gate: assert property (!move.press |->
    !move.heading_valid && !move.heading_away) else $error("heading outside press");
  a_width_role: assert property ((move.press ? move.tolerance : move.press_travel) == 0)
    else $error("width field role wrong");
  a_move_frozen: assert property (!move_start |-> $stable(move))
    else $error("move changed without launch");
endmodule
bind acwd_decoder acwd_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .drive(drive), .move(move), .move_start(move_start), .origin_start(origin_start),
  .move_busy(move_busy), .origin_busy(origin_busy), .move_done(move_done),
  .origin_done(origin_done));

// [tb/acwd_motion_model.sv]
// motion engine stand-in: ends each started motion after lat cycles
`timescale 1ns/1ps
module acwd_motion_model (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       start,
  input wire logic [3:0] lat,
  output logic           done
);
  logic [4:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_ff <= 5'h00;
    else if (start) cnt_ff <= {1'b0, lat} + 5'h01;
    else if (cnt_ff != 5'h00) cnt_ff <= cnt_ff - 5'h01;
  end
  assign done = (cnt_ff == 5'h01);
endmodule

// [tb/acwd_decoder_tb.sv]
// self-checking bench for the control word decoder
`timescale 1ns/1ps
module acwd_decoder_tb;
  import acwd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        move_done, origin_done, move_start, origin_start, move_busy, origin_busy;
  logic [3:0]  lat;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, w;
  acwd_drive_t drive;
  acwd_move_t  move;
  int          errors, checks_done, cyc, mv_cnt, or_cnt, m_ctrl, n;
  acwd_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .move_done(move_done), .origin_done(origin_done), .drive(drive),
    .move(move), .move_start(move_start), .origin_start(origin_start),
    .move_busy(move_busy), .origin_busy(origin_busy));
  acwd_motion_model u_mv (.pclk(pclk), .presetn(presetn), .start(move_start), .lat(lat),
    .done(move_done));
  acwd_motion_model u_or (.pclk(pclk), .presetn(presetn), .start(origin_start), .lat(lat),
    .done(origin_done));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    mv_cnt += move_start;
    or_cnt += origin_start;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string s, input logic [67:0] x, input logic [67:0] g);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  // waits an edge first so back-to-back calls never reassign psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, lat} = '0;
    presetn = 1'b0;
    void'($urandom(51161));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", 68'h0, 68'(r));
    end
    // launch and origin bits kept clear here; motion is exercised below
    for (int i = 0; i < 24; i++) begin
      w = $urandom & 32'h0000_FFFC;
      apb(1'b1, 8'h00, w);
      #1;
      chk("drive", 68'({w[15], w[4], w[2], w[3] & ~m_ctrl[3], w[8:5]}), 68'(drive));
      m_ctrl = w;
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl readback", 68'(w & 32'h0000_F1FF), 68'(r));
    end
    apb(1'b1, 8'h00, 32'h0);
    for (int k = 0; k < 8; k++) begin
      w = $urandom;
      apb(1'b1, 8'h0C, w);
      lat <= 4'($urandom);
      apb(1'b1, 8'h08, 32'(k[1]));
      apb(1'b1, 8'h00, {17'h0, k[1] ^ k[2], k[2], k[0], 12'h001});
      apb(1'b1, 8'h00, 32'h0);
      #1;
      chk("move starts", 68'(k + 1), 68'(mv_cnt));
      chk("move", {k[1] ^ k[2], k[0], k[0] & k[1], k[0] & k[1] & k[2], k[0] ? w : 32'h0,
        k[0] ? 32'h0 : w}, 68'(move));
      n = 0;
      do begin @(posedge pclk); n++; end while (move_busy !== 1'b0 && n < 40);
      chk("move idle", 68'h0, 68'(move_busy));
    end
    apb(1'b1, 8'h00, 32'h3);
    @(posedge pclk);
    #1;
    chk("origin starts", 68'h1, 68'(or_cnt));
    chk("move starts", 68'h8, 68'(mv_cnt));
    chk("origin busy", 68'h1, 68'(origin_busy));
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 68'h1, 68'(e));
    chk("unmapped data", 68'h0, 68'(r));
    conclude();
  end
endmodule
